// *** src/motion_seq_defines.svh ***
// Constants for the motion command list sequencer
`ifndef MOTION_SEQ_DEFINES_SVH
`define MOTION_SEQ_DEFINES_SVH
`define LIST_DEPTH    32
`define FIRST_DEFAULT 6'h01
`define LAST_DEFAULT  6'h20
`define OFS_CTRL      12'h000
`define OFS_STAT      12'h004
`define OFS_FAULT     12'h008
`define OFS_TAG       12'h00c
`define LIST_BASE     12'h200
`define LIST_MASK     12'he00
`define CTRL_START    0
`define CTRL_FIRST    8
`define CTRL_LAST     16
`define STAT_STEP     8
`define ENT_TAG       16
`define CLK_NS        10
`define TICK_NS       1000000
`define FLT_NONE      16'h0000
`define FLT_RANGE     16'h8001
`define FLT_TYPE      16'h8002
`endif

// *** src/motion_seq_pkg.sv ***
// Types shared by the sequencer and its bench
package motion_seq_pkg;
  typedef enum logic [2:0] {
    CMD_EMPTY = 3'h0,
    CMD_HALT  = 3'h1,
    CMD_REL   = 3'h2,
    CMD_ABS   = 3'h3,
    CMD_VEL   = 3'h4,
    CMD_WAIT  = 3'h5,
    CMD_SEP   = 3'h6
  } cmd_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_AXIS  = 2'h2,
    ST_TIME  = 2'h3
  } seq_state_e;
  typedef struct packed {
    cmd_e        kind;
    logic [31:0] target;
    logic [31:0] speed;
  } axis_cmd_s;
endpackage : motion_seq_pkg

// *** src/motion_command_list_sequencer.sv ***
// Command list sequencer for one pulse-train axis with AHB-Lite registers
// Function
// RULE1 - Start only on rising edge of request
// RULE2 - First step defaults 1, within 1..last
// RULE3 - Last step defaults 32, within first..32
// RULE4 - Up to 32 entries run ascending
// RULE5 - Preempted flag set when another job preempts
// RULE6 - Failure sets error, identifier and detail
// RULE7 - Output active step number and tag
// RULE8 - Empty entries skipped without axis action
// RULE9 - Halt acts only after velocity setpoint
// RULE10 - Relative entry moves by stored distance
// RULE11 - Absolute entry moves to stored target
// RULE12 - Velocity entry runs axis continuously
// RULE13 - Wait delays advance, motion keeps going
// RULE14 - Separators split list into independent profiles
// RULE15 - Controller releases and configures axis first
// RULE16 - Other motion jobs preempt running sequence
// RULE17 - New sequence aborts active axis jobs
// RULE18 - Abort occurs at first motion entry launch
// RULE19 - Busy until end; done after success
// RULE20 - Bad step limits reject job with error
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`include "motion_seq_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module motion_command_list_sequencer
  import motion_seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        other_job_start,
  input  wire logic        axis_done,
  output logic             axis_cmd_valid,
  output logic             axis_takeover,
  output axis_cmd_s        axis_cmd
);
  localparam int unsigned DEPTH = `LIST_DEPTH;

  function automatic logic limits_ok(input logic [5:0] f, input logic [5:0] l);
    limits_ok = (f >= 6'h01) && (f <= l) && (l <= 6'(DEPTH));
  endfunction : limits_ok

  function automatic logic [4:0] slot(input logic [5:0] step);
    slot = 5'(step - 6'h01);
  endfunction : slot

  // Command list storage
  cmd_e        kind_q [DEPTH];
  logic [15:0] etag_q [DEPTH];
  logic [31:0] par_q  [DEPTH];
  logic [31:0] vel_q  [DEPTH];
  logic [31:0] per_q  [DEPTH];
  cmd_e        kind_d [DEPTH];
  logic [15:0] etag_d [DEPTH];
  logic [31:0] par_d  [DEPTH];
  logic [31:0] vel_d  [DEPTH];
  logic [31:0] per_d  [DEPTH];

  logic        wr_pend_q, wr_pend_d;
  logic [11:0] waddr_q, waddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        start_req_q, start_req_d, start_prev_q;
  logic [5:0]  first_q, first_d, last_q, last_d;
  seq_state_e  state_q, state_d;
  logic [5:0]  ptr_q, ptr_d, active_q, active_d;
  logic [15:0] tag_q, tag_d, fid_q, fid_d, fdet_q, fdet_d;
  logic        done_q, done_d, busy_q, busy_d, abort_q, abort_d, err_q, err_d;
  logic        vel_seen_q, vel_seen_d, owned_q, owned_d;
  logic [31:0] wait_q, wait_d, tick_q, tick_d;
  logic        valid_q, valid_d, take_q, take_d;
  axis_cmd_s   cmd_q, cmd_d;
  logic        rise;
  logic [4:0]  cs;

  assign rise = start_req_q & ~start_prev_q; // [RULE1]
  assign cs   = slot(ptr_q);

  always_comb begin
    kind_d      = kind_q;
    etag_d      = etag_q;
    par_d       = par_q;
    vel_d       = vel_q;
    per_d       = per_q;
    {wr_pend_d, rdata_d} = 33'h0;
    {waddr_d, start_req_d, first_d, last_d} = {waddr_q, start_req_q, first_q, last_q};
    // Address phase of the slave
    if (hsel && hready && htrans[1]) begin
      wr_pend_d = hwrite;
      waddr_d   = haddr;
      if (!hwrite) begin
        if ((haddr & `LIST_MASK) == `LIST_BASE) begin
          case (haddr[3:2])
            2'h0:    rdata_d = {etag_q[haddr[8:4]], 13'h0, kind_q[haddr[8:4]]};
            2'h1:    rdata_d = par_q[haddr[8:4]];
            2'h2:    rdata_d = vel_q[haddr[8:4]];
            default: rdata_d = per_q[haddr[8:4]];
          endcase
        end else begin
          case (haddr)
            `OFS_CTRL: rdata_d = (32'(start_req_q) << `CTRL_START)
                               | (32'(first_q) << `CTRL_FIRST) | (32'(last_q) << `CTRL_LAST);
            `OFS_STAT: rdata_d = {18'h0, active_q, 4'h0, err_q, abort_q, busy_q, done_q};
            `OFS_FAULT: rdata_d = {fdet_q, fid_q};
            `OFS_TAG:  rdata_d = {16'h0, tag_q};
            default:   rdata_d = 32'h0;
          endcase
        end
      end
    end
    // Data phase of a write
    if (wr_pend_q) begin
      if ((waddr_q & `LIST_MASK) == `LIST_BASE) begin
        case (waddr_q[3:2])
          2'h0: begin
            kind_d[waddr_q[8:4]] = cmd_e'(hwdata[2:0]);
            etag_d[waddr_q[8:4]] = hwdata[`ENT_TAG +: 16];
          end
          2'h1:    par_d[waddr_q[8:4]] = hwdata;
          2'h2:    vel_d[waddr_q[8:4]] = hwdata;
          default: per_d[waddr_q[8:4]] = hwdata;
        endcase
      end else if (waddr_q == `OFS_CTRL) begin
        start_req_d = hwdata[`CTRL_START];
        first_d     = hwdata[`CTRL_FIRST +: 6];
        last_d      = hwdata[`CTRL_LAST +: 6];
      end
    end
  end

  always_comb begin
    state_d    = state_q;
    {ptr_d, active_d, tag_d} = {ptr_q, active_q, tag_q};
    {fid_d, fdet_d} = {fid_q, fdet_q};
    {done_d, busy_d, abort_d, err_d} = {done_q, busy_q, abort_q, err_q};
    {vel_seen_d, owned_d, wait_d, tick_d} = {vel_seen_q, owned_q, wait_q, tick_q};
    {valid_d, take_d} = 2'h0;
    cmd_d      = cmd_q;
    case (state_q)
      ST_FETCH: begin
        if (ptr_q > last_q) begin
          done_d  = 1'b1; // [RULE19]
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end else begin
          active_d = ptr_q; // [RULE7]
          tag_d    = etag_q[cs];
          cmd_d    = '{kind: kind_q[cs], target: par_q[cs], speed: vel_q[cs]};
          case (kind_q[cs])
            CMD_EMPTY: ptr_d = ptr_q + 6'h01; // [RULE8]
            CMD_SEP: begin
              vel_seen_d = 1'b0; // [RULE14]
              ptr_d      = ptr_q + 6'h01;
            end
            CMD_HALT: begin
              ptr_d = ptr_q + 6'h01;
              if (vel_seen_q) begin
                valid_d    = 1'b1; // [RULE9]
                take_d     = ~owned_q; // [RULE18]
                owned_d    = 1'b1;
                vel_seen_d = 1'b0;
                state_d    = ST_AXIS;
              end
            end
            CMD_REL, CMD_ABS: begin
              valid_d = 1'b1; // [RULE10] [RULE11]
              take_d  = ~owned_q; // [RULE17] [RULE18]
              owned_d = 1'b1;
              ptr_d   = ptr_q + 6'h01;
              state_d = ST_AXIS;
            end
            CMD_VEL: begin
              valid_d    = 1'b1; // [RULE12]
              take_d     = ~owned_q; // [RULE18]
              owned_d    = 1'b1;
              vel_seen_d = 1'b1;
              ptr_d      = ptr_q + 6'h01; // [RULE4]
            end
            CMD_WAIT: begin
              ptr_d  = ptr_q + 6'h01;
              wait_d = per_q[cs]; // [RULE13]
              tick_d = 32'h0;
              if (per_q[cs] != 32'h0) begin
                state_d = ST_TIME;
              end
            end
            default: begin
              err_d   = 1'b1; // [RULE6]
              fid_d   = `FLT_TYPE;
              fdet_d  = {10'h0, ptr_q};
              busy_d  = 1'b0;
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_AXIS: begin
        if (axis_done) begin
          state_d = ST_FETCH;
        end
      end
      ST_TIME: begin
        if (tick_q >= TICK_CYCLES - 1) begin
          tick_d = 32'h0;
          wait_d = wait_q - 32'h1;
          if (wait_q <= 32'h1) begin
            state_d = ST_FETCH;
          end
        end else begin
          tick_d = tick_q + 32'h1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (other_job_start && busy_q) begin
      abort_d = 1'b1; // [RULE5] [RULE16]
      busy_d  = 1'b0;
      {valid_d, take_d} = 2'h0;
      state_d = ST_IDLE;
    end
    if (rise) begin
      {valid_d, take_d} = 2'h0;
      {done_d, abort_d} = 2'h0;
      {active_d, tag_d} = 22'h0;
      if (limits_ok(first_q, last_q)) begin
        busy_d     = 1'b1; // [RULE19]
        err_d      = 1'b0;
        {fid_d, fdet_d} = {`FLT_NONE, `FLT_NONE};
        ptr_d      = first_q; // [RULE2] [RULE3]
        {vel_seen_d, owned_d} = 2'h0;
        state_d    = ST_FETCH;
      end else begin
        busy_d  = 1'b0; // [RULE20]
        err_d   = 1'b1;
        fid_d   = `FLT_RANGE;
        fdet_d  = {2'h0, last_q, 2'h0, first_q};
        state_d = ST_IDLE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        kind_q[i] <= CMD_EMPTY;
        etag_q[i] <= 16'h0;
        par_q[i]  <= 32'h0;
        vel_q[i]  <= 32'h0;
        per_q[i]  <= 32'h0;
      end
      {wr_pend_q, start_req_q, start_prev_q, vel_seen_q, owned_q, valid_q, take_q} <= 7'h0;
      {waddr_q, rdata_q, ptr_q, active_q, tag_q} <= 72'h0;
      {wait_q, tick_q} <= 64'h0;
      {fid_q, fdet_q} <= {`FLT_NONE, `FLT_NONE};
      {done_q, busy_q, abort_q, err_q} <= 4'h0;
      first_q      <= `FIRST_DEFAULT;
      last_q       <= `LAST_DEFAULT;
      state_q      <= ST_IDLE;
      cmd_q        <= '0;
    end else begin
      kind_q       <= kind_d;
      etag_q       <= etag_d;
      par_q        <= par_d;
      vel_q        <= vel_d;
      per_q        <= per_d;
      {wr_pend_q, waddr_q, rdata_q} <= {wr_pend_d, waddr_d, rdata_d};
      {start_req_q, start_prev_q}   <= {start_req_d, start_req_q};
      {first_q, last_q}             <= {first_d, last_d};
      state_q                       <= state_d;
      {ptr_q, active_q, tag_q}      <= {ptr_d, active_d, tag_d};
      {fid_q, fdet_q}               <= {fid_d, fdet_d};
      {done_q, busy_q, abort_q, err_q} <= {done_d, busy_d, abort_d, err_d};
      {vel_seen_q, owned_q, valid_q, take_q} <= {vel_seen_d, owned_d, valid_d, take_d};
      {wait_q, tick_q}              <= {wait_d, tick_d};
      cmd_q                         <= cmd_d;
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = rdata_q;
  assign axis_cmd_valid = valid_q;
  assign axis_takeover  = take_q;
  assign axis_cmd       = cmd_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_start_edge: assert property ($rose(busy_q) |-> $past(rise)) // [RULE1]
    else $error("busy rose without a start edge");
  chk_range_reject: assert property (rise && !limits_ok(first_q, last_q) |=> // [RULE20]
    err_q && !busy_q && fid_q == `FLT_RANGE ##1 !axis_cmd_valid)
    else $error("bad limits not rejected");
  chk_step_order: assert property (busy_q && $past(busy_q) && !$past(rise) // [RULE4]
    && $changed(active_q) |-> active_q > $past(active_q))
    else $error("steps not ascending");
  chk_preempt_flag: assert property (other_job_start && busy_q && !rise |=> // [RULE5]
    abort_q && !busy_q && !axis_cmd_valid)
    else $error("preemption not flagged");
  chk_fault_clear: assert property (!err_q && !$past(err_q) |-> fid_q == `FLT_NONE) // [RULE6]
    else $error("fault id without error");
  chk_empty_skip: assert property (state_q == ST_FETCH && ptr_q <= last_q // [RULE8]
    && kind_q[cs] == CMD_EMPTY |=> !axis_cmd_valid)
    else $error("empty entry drove the axis");
  chk_halt_gate: assert property (axis_cmd_valid && axis_cmd.kind == CMD_HALT // [RULE9]
    |-> $past(vel_seen_q))
    else $error("halt without prior velocity");
  chk_takeover_once: assert property (axis_takeover |-> axis_cmd_valid // [RULE18]
    ##1 (!axis_takeover)[*2])
    else $error("takeover not tied to first launch");
  chk_done_end: assert property ($rose(done_q) |-> !busy_q && !err_q // [RULE19]
    && $past(ptr_q) > last_q)
    else $error("done before list end");
  chk_wait_quiet: assert property (state_q == ST_TIME |=> !axis_cmd_valid) // [RULE13]
    else $error("wait issued an axis command");

  cov_done: cover property (busy_q ##[1:400] $rose(done_q));
  cov_abort: cover property (busy_q && other_job_start ##1 abort_q);
  cov_wait: cover property (state_q == ST_TIME ##1 state_q == ST_FETCH);
endmodule : motion_command_list_sequencer
`default_nettype wire

// *** tb/axis_model.sv ***
// Behavioural axis that finishes each move or halt received while stall is low after a short random delay
`timescale 1ns/1ns
`default_nettype none
module axis_model
  import motion_seq_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      stall,
  input  wire logic      axis_cmd_valid,
  input  wire axis_cmd_s axis_cmd,
  output logic           axis_done
);
  int unsigned left;
  always @(posedge mclk) begin
    axis_done <= 1'b0;
    if (reset) begin
      left <= 0;
    end else if (axis_cmd_valid && !stall && axis_cmd.kind != CMD_VEL) begin
      left <= 2 + $urandom % 5;
    end else if (left == 1) begin
      axis_done <= 1'b1;
      left <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule : axis_model
`default_nettype wire

// *** tb/motion_command_list_sequencer_tb_top.sv ***
// Self-checking bench for the command list sequencer
`include "motion_seq_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module motion_command_list_sequencer_tb_top;
  import motion_seq_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        other_job_start = 1'b0;
  logic        stall = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        axis_done;
  logic        axis_cmd_valid;
  logic        axis_takeover;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] s;
  logic [67:0] want;
  logic [67:0] seen;
  logic [67:0] exp_q[$];
  logic [5:0]  bf[3] = '{6'h05, 6'h00, 6'h01};
  logic [5:0]  bl[3] = '{6'h03, 6'h03, 6'h21};
  axis_cmd_s   axis_cmd;
  int          err_total = 0;
  int          tests_run = 0;
  always #5 mclk = ~mclk;
  motion_command_list_sequencer #(.TICK_CYCLES(4)) dut (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .other_job_start(other_job_start), .axis_done(axis_done),
    .axis_cmd_valid(axis_cmd_valid), .axis_takeover(axis_takeover), .axis_cmd(axis_cmd));
  axis_model partner (
    .mclk(mclk), .reset(reset), .stall(stall), .axis_cmd_valid(axis_cmd_valid),
    .axis_cmd(axis_cmd), .axis_done(axis_done));
  task automatic check(input logic [67:0] got, input logic [67:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : ahb
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd & m, exp);
  endtask : rdc
  task automatic ent(input logic [4:0] n, input logic [2:0] k, input logic [15:0] tag,
                     input logic [31:0] t, input logic [31:0] v, input logic [31:0] p);
    ahb(1'b1, `LIST_BASE + {3'h0, n, 4'h0}, {tag, 13'h0, k});
    ahb(1'b1, `LIST_BASE + {3'h0, n, 4'h4}, t);
    ahb(1'b1, `LIST_BASE + {3'h0, n, 4'h8}, v);
    ahb(1'b1, `LIST_BASE + {3'h0, n, 4'hc}, p);
  endtask : ent
  task automatic start(input logic [5:0] f, input logic [5:0] l);
    ahb(1'b1, `OFS_CTRL, {10'h0, l, 2'h0, f, 8'h00});
    ahb(1'b1, `OFS_CTRL, {10'h0, l, 2'h0, f, 8'h01});
  endtask : start
  task automatic wait_idle();
    int i;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 200; i++) begin
      ahb(1'b0, `OFS_STAT, 32'h0);
      if (rd[1] === 1'b0) break;
    end
  endtask : wait_idle
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Oldest queued command against each one the axis receives
  always @(posedge mclk) begin
    if (axis_cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        want = exp_q.pop_front();
        seen = {axis_takeover, axis_cmd};
        check(seen, want);
      end
    end
  end
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  initial begin
    void'($urandom(66255));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdc(`OFS_CTRL, 32'hffffffff, 32'h00200100);
    rdc(`OFS_STAT, 32'hffffffff, 32'h0);
    rdc(`OFS_FAULT, 32'hffffffff, 32'h0);
    rdc(`OFS_TAG, 32'hffffffff, 32'h0);
    rdc(12'h010, 32'hffffffff, 32'h0);
    $display("Test reset values done");
    d = $urandom;
    s = $urandom % 1000 + 1;
    ent(5'd0, CMD_REL, 16'h0011, d, s, 32'h0);
    ent(5'd2, CMD_ABS, 16'h0022, d ^ 32'h5a5a, s + 1, 32'h0);
    ent(5'd3, CMD_HALT, 16'h0033, 32'h0, 32'h0, 32'h0);
    ent(5'd4, CMD_VEL, 16'h0044, 32'h0, s + 2, 32'h0);
    ent(5'd5, CMD_WAIT, 16'h0055, 32'h0, 32'h0, 32'h1);
    ent(5'd6, CMD_HALT, 16'h0066, 32'h0, 32'h0, 32'h0);
    ent(5'd7, CMD_SEP, 16'h0077, 32'h0, 32'h0, 32'h0);
    ent(5'd8, CMD_HALT, 16'h0088, 32'h0, 32'h0, 32'h0);
    exp_q.push_back({1'b1, CMD_REL, d, s});
    exp_q.push_back({1'b0, CMD_ABS, d ^ 32'h5a5a, s + 1});
    exp_q.push_back({1'b0, CMD_VEL, 32'h0, s + 2});
    exp_q.push_back({1'b0, CMD_HALT, 64'h0});
    start(6'd1, 6'd9);
    wait_idle();
    rdc(`OFS_STAT, 32'hf, 32'h1);
    check(exp_q.size(), 0);
    $display("Test list run done");
    ahb(1'b1, `OFS_CTRL, {10'h0, 6'd9, 2'h0, 6'd1, 8'h01});
    repeat (20) @(posedge mclk);
    rdc(`OFS_STAT, 32'hf, 32'h1);
    $display("Test held start done");
    for (int i = 0; i < 3; i++) begin
      start(bf[i], bl[i]);
      repeat (4) @(posedge mclk);
      rdc(`OFS_STAT, 32'hf, 32'h8);
      rdc(`OFS_FAULT, 32'hffffffff, {2'h0, bl[i], 2'h0, bf[i], `FLT_RANGE});
    end
    $display("Test bad limits done");
    stall <= 1'b1;
    ent(5'd0, CMD_REL, 16'hbeef, d, s, 32'h0);
    exp_q.push_back({1'b1, CMD_REL, d, s});
    start(6'd1, 6'd1);
    repeat (6) @(posedge mclk);
    rdc(`OFS_STAT, 32'h3f0f, 32'h0102);
    rdc(`OFS_TAG, 32'hffff, 32'hbeef);
    other_job_start <= 1'b1;
    @(posedge mclk);
    other_job_start <= 1'b0;
    repeat (2) @(posedge mclk);
    rdc(`OFS_STAT, 32'hf, 32'h4);
    check(exp_q.size(), 0);
    $display("Test preemption done");
    ent(5'd0, 3'h7, 16'h0070, 32'h0, 32'h0, 32'h0);
    start(6'd1, 6'd1);
    repeat (4) @(posedge mclk);
    rdc(`OFS_STAT, 32'hf, 32'h8);
    rdc(`OFS_FAULT, 32'hffffffff, {16'h0001, `FLT_TYPE});
    check(exp_q.size(), 0);
    $display("Test bad entry type done");
    end_sim();
  end
endmodule : motion_command_list_sequencer_tb_top
`default_nettype wire
